// *** rtl/live_status_pkg.sv ***
package live_status_pkg;

    // ****************************************************************
    // Register map
    // ****************************************************************
    localparam logic [7:0]  LIVE_STATUS_ADDR   = 8'h2f;
    localparam logic [15:0] LIVE_STATUS_RESET  = 16'h0000;

    // ****************************************************************
    // Field positions
    // ****************************************************************
    localparam int CHAN_FAULT_LSB   = 0;
    localparam int OVERTEMP_BIT     = 4;
    localparam int CHARGE_PUMP_BIT  = 5;
    localparam int REG_5V_BIT       = 6;
    localparam int ANALOG_BIT       = 7;
    localparam int DIGITAL_BIT      = 8;
    localparam int REG_1V8_BIT      = 9;
    localparam int INPUT_SEL_LSB    = 10;
    localparam int BUSY_BIT         = 13;
    localparam int DATA_READY_BIT   = 14;
    localparam int RESERVED_BIT     = 15;

    // ****************************************************************
    // Timing
    // ****************************************************************
    localparam int CLK_FREQ_HZ      = 40_000_000;
    localparam int READY_PULSE_NS   = 24_000;
    localparam int READY_PULSE_CYC  = (READY_PULSE_NS * (CLK_FREQ_HZ / 1_000_000)) / 1000;
    localparam int DEBOUNCE_MS      = 2;
    localparam int DEBOUNCE_CYC     = DEBOUNCE_MS * (CLK_FREQ_HZ / 1000);
    localparam int DEBOUNCE_W       = 17;

    typedef enum logic [1:0] {
        PIN_IDLE_type   = 2'b00,
        PIN_ACTIVE_type = 2'b01,
        PIN_WAIT_type   = 2'b11
    } ready_pin_state_type;

endpackage

// *** rtl/fault_bus_if.sv ***
`timescale 1ns/1ps
interface fault_bus_if;
    logic       raw;
    logic       output_mode;
    logic       clear;
    logic       latched;

    modport owner (output raw, output output_mode, output clear, input latched);
    modport filter (input raw, input output_mode, input clear, output latched);
endinterface

// *** rtl/chan_fault_debounce.sv ***
`timescale 1ns/1ps
module chan_fault_debounce
    import live_status_pkg::*;
(
    input  wire logic   clk_i,
    input  wire logic   reset_i,
    fault_bus_if.filter bus
);

    logic [DEBOUNCE_W-1:0] count_reg;
    logic [DEBOUNCE_W-1:0] count_next;
    logic                  latched_reg;
    logic                  latched_next;

    // ****************************************************************
    // Debounce and sticky flag
    // ****************************************************************
    always_comb begin
        count_next   = count_reg;
        latched_next = latched_reg;
        if (!bus.raw) begin
            count_next = '0;
        end else if (count_reg != DEBOUNCE_W'(DEBOUNCE_CYC)) begin
            count_next = count_reg + 1'b1;
        end
        if (bus.clear) begin
            latched_next = 1'b0;
        end
        // Set wins over a clear in the same cycle
        if (!bus.output_mode && bus.raw) begin
            latched_next = 1'b1;
        end else if (bus.output_mode && count_reg == DEBOUNCE_W'(DEBOUNCE_CYC - 1)) begin
            latched_next = 1'b1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            count_reg   <= '0;
            latched_reg <= 1'b0;
        end else begin
            count_reg   <= count_next;
            latched_reg <= latched_next;
        end
    end

    assign bus.latched = latched_reg;

endmodule

// *** rtl/live_condition_status.sv ***
`timescale 1ns/1ps
module live_condition_status
    import live_status_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        reset_i,
    input  wire logic [7:0]  reg_addr_i,
    input  wire logic        reg_write_i,
    input  wire logic        reg_read_i,
    input  wire logic [15:0] reg_wdata_i,
    output logic      [15:0] reg_rdata_o,
    input  wire logic        conv_done_i,
    input  wire logic        conv_busy_i,
    input  wire logic [2:0]  converting_input_select_i,
    input  wire logic        continuous_mode_i,
    input  wire logic        reg_1v8_live_i,
    input  wire logic        digital_supply_live_i,
    input  wire logic        analog_supply_live_i,
    input  wire logic        reg_5v_live_i,
    input  wire logic        charge_pump_live_i,
    input  wire logic        overtemp_live_i,
    input  wire logic [3:0]  chan_fault_live_i,
    input  wire logic [3:0]  chan_output_mode_i,
    input  wire logic [3:0]  chan_fault_clear_i,
    output logic      [3:0]  chan_fault_latched_o,
    output logic             data_ready_n_o
);

    logic                live_sel;
    logic                data_ready_reg;
    logic                data_ready_next;
    ready_pin_state_type pin_state_reg;
    ready_pin_state_type pin_state_next;
    logic [9:0]          pin_count_reg;
    logic [9:0]          pin_count_next;
    logic                ready_pin_n_next;
    logic [15:0]         rdata_reg;
    logic [15:0]         rdata_next;
    logic [15:0]         live_word;

    assign live_sel = (reg_addr_i == LIVE_STATUS_ADDR);

    // ****************************************************************
    // Conversion-ready flag
    // ****************************************************************
    always_comb begin
        data_ready_next = data_ready_reg;
        if (reg_write_i && live_sel && reg_wdata_i[DATA_READY_BIT]) begin
            data_ready_next = 1'b0;
        end
        if (conv_done_i) begin
            data_ready_next = 1'b1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            data_ready_reg <= 1'b0;
        end else begin
            data_ready_reg <= data_ready_next;
        end
    end

    // ****************************************************************
    // Ready pin timing
    // ****************************************************************
    always_comb begin
        pin_state_next = pin_state_reg;
        pin_count_next = pin_count_reg;
        case (pin_state_reg)
            PIN_IDLE_type: begin
                if (conv_done_i) begin
                    pin_state_next = PIN_ACTIVE_type;
                    pin_count_next = 10'(READY_PULSE_CYC - 1);
                end
            end
            PIN_ACTIVE_type: begin
                if (!continuous_mode_i) begin
                    if (!data_ready_reg) begin
                        pin_state_next = PIN_IDLE_type;
                    end
                end else if (pin_count_reg == 10'h000) begin
                    pin_state_next = PIN_WAIT_type;
                end else begin
                    pin_count_next = pin_count_reg - 1'b1;
                end
            end
            PIN_WAIT_type: begin
                if (conv_done_i) begin
                    pin_state_next = PIN_ACTIVE_type;
                    pin_count_next = 10'(READY_PULSE_CYC - 1);
                end else if (!continuous_mode_i) begin
                    pin_state_next = PIN_IDLE_type;
                end
            end
            default: begin
                pin_state_next = PIN_IDLE_type;
            end
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            pin_state_reg <= PIN_IDLE_type;
            pin_count_reg <= 10'h000;
        end else begin
            pin_state_reg <= pin_state_next;
            pin_count_reg <= pin_count_next;
        end
    end

    // ****************************************************************
    // Pin output, active low
    // ****************************************************************
    always_comb begin
        ready_pin_n_next = (pin_state_next != PIN_ACTIVE_type);
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            data_ready_n_o <= 1'b1;
        end else begin
            data_ready_n_o <= ready_pin_n_next;
        end
    end

    // ****************************************************************
    // Channel fault debounce
    // ****************************************************************
    for (genvar i = 0; i < 4; i++) begin : g_chan
        fault_bus_if fb ();
        assign fb.raw         = chan_fault_live_i[i];
        assign fb.output_mode = chan_output_mode_i[i];
        assign fb.clear       = chan_fault_clear_i[i];
        assign chan_fault_latched_o[i] = fb.latched;
        chan_fault_debounce u_deb (
            .clk_i   (clk_i),
            .reset_i (reset_i),
            .bus     (fb.filter)
        );
    end

    // ****************************************************************
    // Live word and read data
    // ****************************************************************
    always_comb begin
        live_word                                      = LIVE_STATUS_RESET;
        live_word[RESERVED_BIT]                        = 1'b0;
        live_word[DATA_READY_BIT]                      = data_ready_reg;
        live_word[BUSY_BIT]                            = conv_busy_i;
        live_word[INPUT_SEL_LSB +: 3]                  = converting_input_select_i;
        live_word[REG_1V8_BIT]                         = reg_1v8_live_i;
        live_word[DIGITAL_BIT]                         = digital_supply_live_i;
        live_word[ANALOG_BIT]                          = analog_supply_live_i;
        live_word[REG_5V_BIT]                          = reg_5v_live_i;
        live_word[CHARGE_PUMP_BIT]                     = charge_pump_live_i;
        live_word[OVERTEMP_BIT]                        = overtemp_live_i;
        live_word[CHAN_FAULT_LSB +: 4]                 = chan_fault_live_i;
    end

    // Read only samples; no flag or pin state changes on a read
    always_comb begin
        rdata_next = rdata_reg;
        if (reg_read_i) begin
            rdata_next = live_sel ? live_word : 16'h0000;
        end
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            rdata_reg <= LIVE_STATUS_RESET;
        end else begin
            rdata_reg <= rdata_next;
        end
    end

    assign reg_rdata_o = rdata_reg;

endmodule

// *** bench/host_model.sv ***
`timescale 1ns/1ps
// ****
// Host register access
// ****
module host_model (
    input  logic        clk_i,
    output logic [7:0]  addr_o,
    output logic        rd_o,
    output logic        wr_o,
    output logic [15:0] wdata_o,
    input  logic [15:0] rdata_i
);
    initial begin
        addr_o = 8'h00;
        rd_o = 1'b0;
        wr_o = 1'b0;
        wdata_o = 16'h0000;
    end
    task rd(input logic [7:0] a, output logic [15:0] d);
        @(posedge clk_i);
        addr_o <= a;
        rd_o <= 1'b1;
        @(posedge clk_i);
        rd_o <= 1'b0;
        addr_o <= ~a;
        #1 d = rdata_i;
    endtask
    task wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk_i);
        addr_o <= a;
        wdata_o <= d;
        wr_o <= 1'b1;
        @(posedge clk_i);
        wr_o <= 1'b0;
        wdata_o <= ~d;
    endtask
endmodule

// *** bench/live_status_chk.sv ***
`timescale 1ns/1ps
module live_status_chk import live_status_pkg::*; (
    input logic        clk_i,
    input logic        reset_i,
    input logic [7:0]  reg_addr_i,
    input logic        reg_read_i,
    input logic        reg_write_i,
    input logic [15:0] reg_wdata_i,
    input logic [15:0] reg_rdata_o,
    input logic        conv_done_i,
    input logic        conv_busy_i,
    input logic [2:0]  converting_input_select_i,
    input logic        continuous_mode_i,
    input logic [3:0]  chan_fault_live_i,
    input logic [3:0]  chan_output_mode_i,
    input logic [3:0]  chan_fault_latched_o,
    input logic        data_ready_n_o
);
    // ****
    // Helpers
    // ****
    logic [10:0] low_cnt;
    logic [10:0] low_cnt_next;
    logic        hit;
    logic [3:0]  direct;
    logic        clr_wr;
    assign hit = reg_read_i && reg_addr_i == LIVE_STATUS_ADDR;
    assign clr_wr = reg_write_i && reg_wdata_i[14];
    assign direct = chan_fault_live_i & ~chan_output_mode_i;
    always_comb low_cnt_next = data_ready_n_o ? 11'h000 : low_cnt + 11'h001;
    always_ff @(posedge clk_i) low_cnt <= reset_i ? 11'h000 : low_cnt_next;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (reset_i);
    // ****
    // Checks
    // ****
    a_reset_state: assert property (disable iff (1'b0) reset_i |=> data_ready_n_o && reg_rdata_o == 16'h0000)
        else $error("reset state wrong");
    a_rsvd_zero: assert property (hit |=> !reg_rdata_o[15])
        else $error("reserved bit set");
    a_unmapped_zero: assert property (reg_read_i && !hit |=> reg_rdata_o == 16'h0000)
        else $error("unmapped read not zero");
    a_busy_input: assert property (hit |=> reg_rdata_o[13:10] == {$past(conv_busy_i), $past(converting_input_select_i)})
        else $error("busy or input code wrong");
    a_chan_mirror: assert property (hit |=> reg_rdata_o[3:0] == $past(chan_fault_live_i))
        else $error("channel bits wrong");
    a_done_pin: assert property (conv_done_i |=> !data_ready_n_o)
        else $error("ready pin not asserted");
    a_single_hold: assert property (!continuous_mode_i && !data_ready_n_o && !clr_wr && !$past(clr_wr) |=> !data_ready_n_o)
        else $error("ready pin released early");
    a_cont_pulse: assert property (continuous_mode_i && $rose(data_ready_n_o) |-> low_cnt == READY_PULSE_CYC)
        else $error("continuous pulse length wrong");
    a_direct_latch: assert property (1'b1 |=> (chan_fault_latched_o & $past(direct)) == $past(direct))
        else $error("channel fault not latched");
    cover property (hit);
    cover property (conv_done_i && continuous_mode_i);
    cover property (|chan_fault_latched_o);
endmodule
bind live_condition_status live_status_chk chk(.*);

// *** bench/live_status_register_test.sv ***
`timescale 1ns/1ps
module live_status_register_test import live_status_pkg::*; ();
    logic        clk_i = 1'b0;
    logic        reset_i = 1'b1;
    logic [7:0]  reg_addr_i;
    logic        reg_write_i, reg_read_i, data_ready_n_o;
    logic [15:0] reg_wdata_i, reg_rdata_o, d, e;
    logic        conv_done_i = 1'b0, conv_busy_i = 1'b0, continuous_mode_i = 1'b0;
    logic [2:0]  converting_input_select_i = 3'h0;
    logic        reg_1v8_live_i = 1'b0, digital_supply_live_i = 1'b0, analog_supply_live_i = 1'b0;
    logic        reg_5v_live_i = 1'b0, charge_pump_live_i = 1'b0, overtemp_live_i = 1'b0;
    logic [3:0]  chan_fault_live_i = 4'h0, chan_output_mode_i = 4'h0, chan_fault_clear_i = 4'h0;
    logic [3:0]  chan_fault_latched_o;
    int          bad_count = 0, comparisons = 0, n;
    live_condition_status DUT(.*);
    host_model host(.clk_i(clk_i), .addr_o(reg_addr_i), .rd_o(reg_read_i), .wr_o(reg_write_i),
                    .wdata_o(reg_wdata_i), .rdata_i(reg_rdata_o));
    initial forever #12.5 clk_i = ~clk_i;
    // ****
    // Scenarios
    // ****
    task chk(input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            bad_count++;
            $display("wrong value at %0t: got %h want %h", $time, seen, exp);
        end
    endtask
    task print_verdict;
        if (bad_count == 0 && comparisons > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task pulse_done;
        @(posedge clk_i);
        conv_done_i <= 1'b1;
        @(posedge clk_i);
        conv_done_i <= 1'b0;
        #1;
    endtask
    task t_live;
        for (int i = 0; i < 8; i++) begin
            @(posedge clk_i);
            converting_input_select_i <= i[2:0];
            conv_busy_i <= i[0];
            {reg_1v8_live_i, digital_supply_live_i, analog_supply_live_i, reg_5v_live_i} <= 4'h1 << i[1:0];
            charge_pump_live_i <= i[1];
            overtemp_live_i <= i[2];
            chan_fault_live_i <= 4'h8 >> i[1:0];
            e = {2'b00, i[0], i[2:0], 4'h1 << i[1:0], i[1], i[2], 4'h8 >> i[1:0]};
            host.rd(LIVE_STATUS_ADDR, d);
            chk(d, e);
        end
        host.wr(LIVE_STATUS_ADDR, 16'hbfff);
        host.rd(LIVE_STATUS_ADDR, d);
        chk(d, e);
        host.rd(8'h2e, d);
        chk(d, 16'h0000);
        @(posedge clk_i);
        {conv_busy_i, reg_1v8_live_i, digital_supply_live_i, analog_supply_live_i, reg_5v_live_i} <= 5'h00;
        {converting_input_select_i, charge_pump_live_i, overtemp_live_i, chan_fault_live_i} <= 9'h000;
        chan_fault_clear_i <= 4'hf;
        @(posedge clk_i);
        chan_fault_clear_i <= 4'h0;
        host.rd(LIVE_STATUS_ADDR, d);
        chk(d, 16'h0000);
        chk({12'h000, chan_fault_latched_o}, 16'h0000);
    endtask
    task t_single;
        pulse_done;
        chk({15'h0000, data_ready_n_o}, 16'h0000);
        host.wr(LIVE_STATUS_ADDR, 16'hbfff);
        host.rd(LIVE_STATUS_ADDR, d);
        chk(d, 16'h4000);
        chk({15'h0000, data_ready_n_o}, 16'h0000);
        host.wr(LIVE_STATUS_ADDR, 16'h4000);
        @(posedge clk_i);
        #1 chk({15'h0000, data_ready_n_o}, 16'h0001);
        host.rd(LIVE_STATUS_ADDR, d);
        chk(d, 16'h0000);
    endtask
    task t_cont;
        @(posedge clk_i);
        continuous_mode_i <= 1'b1;
        pulse_done;
        n = 0;
        while (data_ready_n_o !== 1'b1 && n < 2000) begin
            @(posedge clk_i);
            #1 n++;
        end
        chk(16'(n), 16'(READY_PULSE_CYC));
        if (n == 2000) begin
            bad_count++;
            print_verdict;
        end
        host.rd(LIVE_STATUS_ADDR, d);
        chk(d, 16'h4000);
        host.wr(LIVE_STATUS_ADDR, 16'h4000);
        continuous_mode_i <= 1'b0;
    endtask
    task t_chan;
        @(posedge clk_i);
        chan_output_mode_i <= 4'h4;
        chan_fault_live_i <= 4'h6;
        repeat (100) @(posedge clk_i);
        chan_fault_clear_i <= 4'h2;
        @(posedge clk_i);
        chan_fault_clear_i <= 4'h0;
        chan_fault_live_i <= 4'h0;
        #1 chk({12'h000, chan_fault_latched_o}, 16'h0002);
        host.rd(LIVE_STATUS_ADDR, d);
        chk(d, 16'h0000);
        @(posedge clk_i);
        chan_fault_live_i <= 4'h4;
        repeat (DEBOUNCE_CYC - 1) @(posedge clk_i);
        #1 chk({12'h000, chan_fault_latched_o}, 16'h0002);
        @(posedge clk_i);
        #1 chk({12'h000, chan_fault_latched_o}, 16'h0006);
        host.rd(LIVE_STATUS_ADDR, d);
        chk(d, 16'h0004);
        @(posedge clk_i);
        chan_fault_clear_i <= 4'h6;
        @(posedge clk_i);
        chan_fault_clear_i <= 4'h0;
        chan_fault_live_i <= 4'h0;
        #1 chk({12'h000, chan_fault_latched_o}, 16'h0000);
    endtask
    task t_reset;
        @(posedge clk_i);
        chan_fault_live_i <= 4'h1;
        pulse_done;
        host.rd(LIVE_STATUS_ADDR, d);
        chk(d, 16'h4001);
        @(posedge clk_i);
        reset_i <= 1'b1;
        chan_fault_live_i <= 4'h0;
        repeat (2) @(posedge clk_i);
        reset_i <= 1'b0;
        #1 chk({15'h0000, data_ready_n_o}, 16'h0001);
        chk(reg_rdata_o, LIVE_STATUS_RESET);
        chk({12'h000, chan_fault_latched_o}, 16'h0000);
        host.rd(LIVE_STATUS_ADDR, d);
        chk(d, LIVE_STATUS_RESET);
    endtask
    initial begin
        repeat (8) @(posedge clk_i);
        reset_i <= 1'b0;
        #1 chk({15'h0000, data_ready_n_o}, 16'h0001);
        host.rd(LIVE_STATUS_ADDR, d);
        chk(d, LIVE_STATUS_RESET);
        t_live;
        t_single;
        t_cont;
        t_chan;
        t_reset;
        print_verdict;
    end
endmodule
